/* File: logic/csr_pkg.sv */
// Purpose: constants and carrier types for the cluster shared word block
// Assumes: one system clock, synchronous active-high reset
// Notes: processor count and cluster count are fixed here
package csr_pkg;
    // ==========================================================
    // sizes
    localparam int NUM_PROC = 4;
    localparam int NUM_CLUSTER = 2;
    localparam int PROC_IDX_W = 2;
    localparam int CLUSTER_IDX_W = 1;
    localparam int ADDR_WORDS = 8;
    localparam int SCALAR_WORDS = 8;
    localparam int SEM_FLAGS = 32;
    localparam int ADDR_W = 32;
    localparam int SCALAR_W = 64;
    localparam int WORD_SEL_W = 3;
    localparam int SEM_SEL_W = 5;
    // ==========================================================
    // reset values
    localparam logic [ADDR_W-1:0] ADDR_WORD_RST = 32'h0000_0000;
    localparam logic [SCALAR_W-1:0] SCALAR_WORD_RST = 64'h0;
    localparam logic [SEM_FLAGS-1:0] SEM_RST = 32'h0000_0000;
    localparam logic [CLUSTER_IDX_W-1:0] CLUSTER_OF_PROC_RST = 1'h0;
    // ==========================================================
    // operations issued by a processor
    typedef enum logic [3:0] {
        CSR_OP_NONE = 4'h0,
        CSR_OP_ADDR_WR = 4'h1,
        CSR_OP_ADDR_RD = 4'h2,
        CSR_OP_SCALAR_WR = 4'h3,
        CSR_OP_SCALAR_RD = 4'h4,
        CSR_OP_SEM_SET = 4'h5,
        CSR_OP_SEM_CLR = 4'h6,
        CSR_OP_SEM_TAS = 4'h7,
        CSR_OP_SEM_RD_ALL = 4'h8,
        CSR_OP_SEM_WR_ALL = 4'h9,
        CSR_OP_IPI = 4'hA
    } csr_op_type;

    typedef struct packed {
        csr_op_type op;
        logic [SEM_SEL_W-1:0] sel;
        logic [PROC_IDX_W-1:0] target;
        logic [ADDR_W-1:0] addr_data;
        logic [SCALAR_W-1:0] scalar_data;
    } csr_req_type;

    typedef struct packed {
        logic addr_valid;
        logic [ADDR_W-1:0] addr_data;
        logic scalar_valid;
        logic [SCALAR_W-1:0] scalar_data;
    } csr_rsp_type;
endpackage

/* File: logic/csr_shared_unit.sv */
// Purpose: shared address words, shared scalar words, semaphore flags, ipi
// Assumes: one request per processor per cycle, in monitor flag per processor
// Notes: writes land at the edge; reads answer one cycle after the request
//        a waiting processor keeps its cluster binding until granted
//        word collisions resolve to the highest processor index
//
// What this block does
// - eight 32-bit shared address words per cluster
// - eight 64-bit shared scalar words per cluster
// - thirty-two one-bit semaphore flags per cluster
// - identical clusters; processor reaches own cluster only
// - one processor writes, cluster peers read back
// - address words to address path, scalar to scalar
// - set or clear any single semaphore flag
// - test-and-set stalls until peer clears flag
// - read or load all 32 flags via scalar
// - monitor-mode processor may interrupt any processor
// - interrupted processor switches into monitor mode
`timescale 1ns/1ps
`default_nettype none
module csr_shared_unit
    import csr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire csr_req_type [NUM_PROC-1:0] i_req,
    input wire logic [NUM_PROC-1:0] i_monitor_mode,
    input wire logic [NUM_PROC*CLUSTER_IDX_W-1:0] i_cluster_sel,
    input wire logic [NUM_PROC-1:0] i_cluster_load,
    output csr_rsp_type [NUM_PROC-1:0] o_rsp,
    output logic [NUM_PROC-1:0] o_issue_hold,
    output logic [NUM_PROC-1:0] o_monitor_enter
);
    // ==========================================================
    // storage
    logic [ADDR_W-1:0] addr_word_r [NUM_CLUSTER][ADDR_WORDS];
    logic [SCALAR_W-1:0] scalar_word_r [NUM_CLUSTER][SCALAR_WORDS];
    logic [SEM_FLAGS-1:0] sem_r [NUM_CLUSTER];
    logic [SEM_FLAGS-1:0] sem_nxt [NUM_CLUSTER];
    logic [CLUSTER_IDX_W-1:0] cluster_of_r [NUM_PROC];
    logic [NUM_PROC-1:0] wait_r;
    logic [NUM_PROC-1:0] wait_nxt;
    logic [SEM_SEL_W-1:0] wait_sel_r [NUM_PROC];
    logic [NUM_PROC-1:0] tas_win;
    csr_rsp_type [NUM_PROC-1:0] rsp_nxt;
    logic [NUM_PROC-1:0] ipi_nxt;
    logic [NUM_PROC-1:0] ipi_ok;
    logic [ADDR_W-1:0] addr_word_nxt [NUM_CLUSTER][ADDR_WORDS];
    logic [SCALAR_W-1:0] scalar_word_nxt [NUM_CLUSTER][SCALAR_WORDS];
    logic [NUM_CLUSTER-1:0] sem_ld_hit;
    logic [SEM_FLAGS-1:0] sem_ld_val [NUM_CLUSTER];
    logic [SEM_FLAGS-1:0] sem_clr_mask [NUM_CLUSTER];
    logic [SEM_FLAGS-1:0] sem_set_mask [NUM_CLUSTER];
    logic [ADDR_W-1:0] addr_rd_word [NUM_PROC];
    logic [SCALAR_W-1:0] scalar_rd_word [NUM_PROC];

    // ==========================================================
    // cluster binding, changed only by explicit load
    always_ff @(posedge i_core_clk) begin
        for (int p = 0; p < NUM_PROC; p++) begin
            if (i_rst) begin
                cluster_of_r[p] <= CLUSTER_OF_PROC_RST;
            end else if (i_cluster_load[p] && !wait_r[p]) begin
                // moving a waiter would retarget its pending flag
                cluster_of_r[p] <=
                    i_cluster_sel[p*CLUSTER_IDX_W +: CLUSTER_IDX_W];
            end
        end
    end

    // ==========================================================
    // shared words; higher processor index wins same-word collisions
    always_comb begin
        logic [CLUSTER_IDX_W-1:0] c;
        logic [WORD_SEL_W-1:0] w;
        c = '0;
        w = '0;
        for (int k = 0; k < NUM_CLUSTER; k++) begin
            for (int j = 0; j < ADDR_WORDS; j++) begin
                addr_word_nxt[k][j] = addr_word_r[k][j];
            end
            for (int j = 0; j < SCALAR_WORDS; j++) begin
                scalar_word_nxt[k][j] = scalar_word_r[k][j];
            end
        end
        // later processors overwrite earlier ones in this loop
        for (int p = 0; p < NUM_PROC; p++) begin
            c = cluster_of_r[p];
            w = i_req[p].sel[WORD_SEL_W-1:0];
            if (i_req[p].op == CSR_OP_ADDR_WR) begin
                addr_word_nxt[c][w] = i_req[p].addr_data;
            end
            if (i_req[p].op == CSR_OP_SCALAR_WR) begin
                scalar_word_nxt[c][w] = i_req[p].scalar_data;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        for (int k = 0; k < NUM_CLUSTER; k++) begin
            for (int j = 0; j < ADDR_WORDS; j++) begin
                if (i_rst) begin
                    addr_word_r[k][j] <= ADDR_WORD_RST;
                end else begin
                    addr_word_r[k][j] <= addr_word_nxt[k][j];
                end
            end
            for (int j = 0; j < SCALAR_WORDS; j++) begin
                if (i_rst) begin
                    scalar_word_r[k][j] <= SCALAR_WORD_RST;
                end else begin
                    scalar_word_r[k][j] <= scalar_word_nxt[k][j];
                end
            end
        end
    end

    // ==========================================================
    // this cycle's flag edits gathered per cluster
    always_comb begin
        logic [CLUSTER_IDX_W-1:0] c;
        c = '0;
        for (int k = 0; k < NUM_CLUSTER; k++) begin
            sem_ld_hit[k] = 1'b0;
            sem_ld_val[k] = sem_r[k];
            sem_clr_mask[k] = '0;
            sem_set_mask[k] = '0;
        end
        for (int p = 0; p < NUM_PROC; p++) begin
            c = cluster_of_r[p];
            unique case (i_req[p].op)
                CSR_OP_SEM_WR_ALL: begin
                    sem_ld_hit[c] = 1'b1;
                    sem_ld_val[c] = i_req[p].scalar_data[SEM_FLAGS-1:0];
                end
                CSR_OP_SEM_CLR: begin
                    sem_clr_mask[c][i_req[p].sel] = 1'b1;
                end
                CSR_OP_SEM_SET: begin
                    sem_set_mask[c][i_req[p].sel] = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // semaphore next state; clears applied before sets and grants
    always_comb begin
        logic [CLUSTER_IDX_W-1:0] c;
        c = '0;
        for (int k = 0; k < NUM_CLUSTER; k++) begin
            sem_nxt[k] = sem_r[k];
        end
        tas_win = '0;
        wait_nxt = wait_r;
        // whole-register loads first, then clears, then sets
        for (int k = 0; k < NUM_CLUSTER; k++) begin
            if (sem_ld_hit[k]) begin
                sem_nxt[k] = sem_ld_val[k];
            end
            sem_nxt[k] = sem_nxt[k] & ~sem_clr_mask[k];
            sem_nxt[k] = sem_nxt[k] | sem_set_mask[k];
        end
        // fixed priority, lowest index first; waiters retry each cycle
        for (int p = 0; p < NUM_PROC; p++) begin
            c = cluster_of_r[p];
            if (wait_r[p]) begin
                if (!sem_nxt[c][wait_sel_r[p]]) begin
                    sem_nxt[c][wait_sel_r[p]] = 1'b1;
                    wait_nxt[p] = 1'b0;
                end
            end else if (i_req[p].op == CSR_OP_SEM_TAS) begin
                if (!sem_r[c][i_req[p].sel] &&
                    !sem_nxt[c][i_req[p].sel]) begin
                    sem_nxt[c][i_req[p].sel] = 1'b1;
                    tas_win[p] = 1'b1;
                end else begin
                    wait_nxt[p] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int k = 0; k < NUM_CLUSTER; k++) begin
                sem_r[k] <= SEM_RST;
            end
        end else begin
            for (int k = 0; k < NUM_CLUSTER; k++) begin
                sem_r[k] <= sem_nxt[k];
            end
        end
    end

    // ==========================================================
    // test-and-set waiting state drives the issue hold
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wait_r <= '0;
            o_issue_hold <= '0;
            for (int p = 0; p < NUM_PROC; p++) begin
                wait_sel_r[p] <= '0;
            end
        end else begin
            wait_r <= wait_nxt;
            o_issue_hold <= wait_nxt;
            for (int p = 0; p < NUM_PROC; p++) begin
                if (!wait_r[p] && i_req[p].op == CSR_OP_SEM_TAS) begin
                    wait_sel_r[p] <= i_req[p].sel;
                end
            end
        end
    end

    // ==========================================================
    // read selection per processor from its own cluster only
    always_comb begin
        logic [CLUSTER_IDX_W-1:0] c;
        logic [WORD_SEL_W-1:0] w;
        c = '0;
        w = '0;
        for (int p = 0; p < NUM_PROC; p++) begin
            c = cluster_of_r[p];
            w = i_req[p].sel[WORD_SEL_W-1:0];
            addr_rd_word[p] = addr_word_r[c][w];
            scalar_rd_word[p] = scalar_word_r[c][w];
        end
    end

    // ==========================================================
    // read answers, taken from state before this cycle's writes
    always_comb begin
        logic [CLUSTER_IDX_W-1:0] c;
        c = '0;
        for (int p = 0; p < NUM_PROC; p++) begin
            c = cluster_of_r[p];
            rsp_nxt[p] = '0;
            unique case (i_req[p].op)
                CSR_OP_ADDR_RD: begin
                    rsp_nxt[p].addr_valid = 1'b1;
                    rsp_nxt[p].addr_data = addr_rd_word[p];
                end
                CSR_OP_SCALAR_RD: begin
                    rsp_nxt[p].scalar_valid = 1'b1;
                    rsp_nxt[p].scalar_data = scalar_rd_word[p];
                end
                CSR_OP_SEM_RD_ALL: begin
                    rsp_nxt[p].scalar_valid = 1'b1;
                    rsp_nxt[p].scalar_data =
                        {{(SCALAR_W-SEM_FLAGS){1'b0}}, sem_r[c]};
                end
                default: begin
                    rsp_nxt[p] = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rsp <= '0;
        end else begin
            o_rsp <= rsp_nxt;
        end
    end

    // ==========================================================
    // interprocessor interrupt; ignored unless sender is in monitor mode
    always_comb begin
        ipi_ok = '0;
        ipi_nxt = '0;
        // user-mode senders are dropped silently, no error is raised
        for (int p = 0; p < NUM_PROC; p++) begin
            ipi_ok[p] = (i_req[p].op == CSR_OP_IPI) && i_monitor_mode[p];
        end
        for (int p = 0; p < NUM_PROC; p++) begin
            if (ipi_ok[p]) begin
                ipi_nxt[i_req[p].target] = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_monitor_enter <= '0;
        end else begin
            o_monitor_enter <= ipi_nxt;
        end
    end
endmodule // csr_shared_unit
`default_nettype wire

/* File: verification/csr_chk.sv */
// Purpose: port checks for the shared word unit
// Assumes: one clock, sync reset
// Notes: detail kept on processors 0, 1 and 3
`timescale 1ns/1ps
`default_nettype none
module csr_chk
    import csr_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire csr_req_type [NUM_PROC-1:0] i_req,
    input wire logic [NUM_PROC-1:0] i_monitor_mode,
    input wire logic [NUM_PROC*CLUSTER_IDX_W-1:0] i_cluster_sel,
    input wire logic [NUM_PROC-1:0] i_cluster_load,
    input wire csr_rsp_type [NUM_PROC-1:0] o_rsp,
    input wire logic [NUM_PROC-1:0] o_issue_hold,
    input wire logic [NUM_PROC-1:0] o_monitor_enter
);
    // ==========================================================
    // helpers
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic any_ipi;
    always_comb begin
        any_ipi = 1'b0;
        for (int p = 0; p < NUM_PROC; p++) begin
            any_ipi |= (i_req[p].op == CSR_OP_IPI) && i_monitor_mode[p];
        end
    end
    sequence s_ipi0;
        i_req[0].op == CSR_OP_IPI && i_monitor_mode[0];
    endsequence
    // both free, same flag, same edge
    sequence s_race;
        i_req[0].op == CSR_OP_SEM_TAS && i_req[1].op == CSR_OP_SEM_TAS &&
        i_req[0].sel == i_req[1].sel && o_issue_hold[1:0] == 2'h0;
    endsequence
    // ==========================================================
    // assertions
    a_ipi_enter: assert property (s_ipi0 |=>
        o_monitor_enter[$past(i_req[0].target)]) else $error("ipi lost");
    a_ipi_cause: assert property (o_monitor_enter != '0 |->
        $past(any_ipi)) else $error("monitor entry without ipi");
    a_addr_rd: assert property (i_req[1].op == CSR_OP_ADDR_RD |=>
        o_rsp[1].addr_valid && !o_rsp[1].scalar_valid)
        else $error("address read answer wrong");
    a_addr_cause: assert property (o_rsp[1].addr_valid |->
        $past(i_req[1].op == CSR_OP_ADDR_RD)) else $error("stray addr");
    a_scal_rd: assert property (i_req[3].op == CSR_OP_SCALAR_RD |=>
        o_rsp[3].scalar_valid && !o_rsp[3].addr_valid)
        else $error("scalar read answer wrong");
    a_rdall_upper: assert property (i_req[1].op == CSR_OP_SEM_RD_ALL |=>
        o_rsp[1].scalar_valid && o_rsp[1].scalar_data[63:32] == '0)
        else $error("flag copy wrong");
    a_hold_cause: assert property ($rose(o_issue_hold[1]) |->
        $past(i_req[1].op == CSR_OP_SEM_TAS)) else $error("stray hold");
    a_race_one: assert property (s_race |=> o_issue_hold[1:0] != 2'h0)
        else $error("two winners");
    a_race_win: assert property (s_race |=> o_issue_hold[1:0] != 2'h3)
        else $error("no winner");
    a_rst_quiet: assert property (disable iff (1'b0) i_rst |=>
        o_issue_hold == '0 && o_monitor_enter == '0)
        else $error("outputs active in reset");
endmodule // csr_chk
bind csr_shared_unit csr_chk u_csr_chk (.i_core_clk, .i_rst, .i_req,
    .i_monitor_mode, .i_cluster_sel, .i_cluster_load, .o_rsp,
    .o_issue_hold, .o_monitor_enter);
`default_nettype wire

/* File: verification/csr_proc_model.sv */
// Purpose: processor side, issues one request per processor
// Assumes: bench fills nxt between edges
// Notes: requests change only at the rising edge
`timescale 1ns/1ps
`default_nettype none
module csr_proc_model
    import csr_pkg::*;
(
    input wire logic i_core_clk,
    output var csr_req_type [NUM_PROC-1:0] o_req
);
    csr_req_type [NUM_PROC-1:0] nxt = '0;
    initial o_req = '0;
    always @(posedge i_core_clk) begin
        o_req <= nxt;
    end
endmodule // csr_proc_model
`default_nettype wire

/* File: verification/csr_shared_unit_tb.sv */
// Purpose: self-checking bench for the shared word unit
// Assumes: 100 MHz clock, sync active-high reset
// Notes: processor 3 moves to cluster 1 early on
`timescale 1ns/1ps
`default_nettype none
module csr_shared_unit_tb
    import csr_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rst_n = 1'b1;
    logic [NUM_PROC-1:0] mon = '0, mon_n = '0, ld = '0, ld_n = '0;
    logic [NUM_PROC*CLUSTER_IDX_W-1:0] csel = '0, csel_n = '0;
    csr_req_type [NUM_PROC-1:0] req;
    csr_rsp_type [NUM_PROC-1:0] rsp;
    logic [NUM_PROC-1:0] hold, ent;
    int fail_count = 0;
    int checked = 0;
    always #5 clk = ~clk;
    always @(posedge clk) {rst, mon, ld, csel} <= {rst_n, mon_n, ld_n, csel_n};
    csr_proc_model u_csr_proc_model (.i_core_clk(clk), .o_req(req));
    csr_shared_unit u_csr_shared_unit (.i_core_clk(clk), .i_rst(rst),
        .i_req(req), .i_monitor_mode(mon), .i_cluster_sel(csel),
        .i_cluster_load(ld), .o_rsp(rsp), .o_issue_hold(hold),
        .o_monitor_enter(ent));
    // ==========================================================
    // helpers
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(int n = 1);
        repeat (n) begin
            @(posedge clk);
            #1;
            u_csr_proc_model.nxt = '0;
        end
    endtask
    task automatic put(int p, csr_op_type op, int s, logic [63:0] d);
        u_csr_proc_model.nxt[p] = '{op, s[4:0], d[1:0], d[31:0], d};
    endtask
    task automatic end_sim();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // grant may land one edge late, so allow a short bound
    task automatic wait_free(int p);
        for (int n = 0; hold[p] !== 1'b0; n++) begin
            if (n == 3) begin
                chk("hold release", 64'h1, 64'h0);
                end_sim();
            end
            cyc();
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic t_words();
        put(0, CSR_OP_ADDR_WR, 3, 64'hA5A5_0F0F_1234_5678);
        put(2, CSR_OP_SCALAR_WR, 7, 64'hFEDC_BA98_7654_3210);
        cyc();
        put(1, CSR_OP_ADDR_RD, 3, 64'h0);
        put(3, CSR_OP_SCALAR_RD, 7, 64'h0);
        cyc(2);
        chk("addr word", rsp[1].addr_data, 64'h1234_5678);
        chk("addr path", {rsp[1].addr_valid, rsp[1].scalar_valid}, 64'h2);
        chk("scalar word", rsp[3].scalar_data, 64'hFEDC_BA98_7654_3210);
        csel_n[3] = 1'b1;
        ld_n[3] = 1'b1;
        cyc();
        ld_n = '0;
        cyc();
        put(3, CSR_OP_ADDR_WR, 3, 64'h9);
        cyc();
        put(3, CSR_OP_ADDR_RD, 3, 64'h0);
        put(1, CSR_OP_ADDR_RD, 3, 64'h0);
        cyc(2);
        chk("other cluster", rsp[3].addr_data, 64'h9);
        chk("own cluster", rsp[1].addr_data, 64'h1234_5678);
    endtask
    task automatic t_sem();
        put(0, CSR_OP_SEM_WR_ALL, 0, 64'hFFFF_FFFF_8000_0001);
        cyc();
        put(1, CSR_OP_SEM_RD_ALL, 0, 64'h0);
        put(0, CSR_OP_SEM_SET, 4, 64'h0);
        cyc();
        put(1, CSR_OP_SEM_CLR, 31, 64'h0);
        put(2, CSR_OP_SEM_TAS, 5, 64'h0);
        cyc();
        chk("flag copy", rsp[1].scalar_data, 64'h8000_0001);
        put(1, CSR_OP_SEM_RD_ALL, 0, 64'h0);
        cyc(2);
        chk("set clr tas", rsp[1].scalar_data, 64'h31);
        chk("tas free", hold[2], 64'h0);
        put(1, CSR_OP_SEM_TAS, 5, 64'h0);
        cyc(4);
        chk("tas stall", hold[1], 64'h1);
        put(2, CSR_OP_SEM_CLR, 5, 64'h0);
        cyc();
        wait_free(1);
        put(0, CSR_OP_SEM_RD_ALL, 0, 64'h0);
        cyc(2);
        chk("grant sets", rsp[0].scalar_data, 64'h31);
        put(0, CSR_OP_SEM_TAS, 9, 64'h0);
        put(1, CSR_OP_SEM_TAS, 9, 64'h0);
        cyc(2);
        chk("one winner", hold[1:0], 64'h2);
        put(2, CSR_OP_SEM_CLR, 9, 64'h0);
        cyc();
        wait_free(1);
    endtask
    task automatic t_ipi();
        mon_n = 4'h1;
        put(1, CSR_OP_IPI, 0, 64'h2);
        cyc(2);
        chk("user ipi", ent, 64'h0);
        put(0, CSR_OP_IPI, 0, 64'h3);
        cyc(2);
        chk("ipi enter", ent, 64'h8);
        cyc();
        chk("ipi pulse", ent, 64'h0);
    endtask
    initial begin
        cyc(10);
        rst_n = 1'b0;
        cyc();
        t_words();
        $display("words done");
        t_sem();
        $display("flags done");
        t_ipi();
        $display("ipi done");
        end_sim();
    end
endmodule // csr_shared_unit_tb
`default_nettype wire
